// file: byte_alu.sv
// Byte ALU slice: subtract, swap, exclusive-OR and direction load
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module byte_alu
    import alu_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Direction latches
    output logic [DATA_W-1:0] dir_latch_port_a,
    output logic [DATA_W-1:0] dir_latch_port_b,
    output logic [DATA_W-1:0] dir_latch_port_c
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] file_mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] result;
    logic [31:0] ctrl;
    logic carry;
    logic nib;
    logic zero;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wr_en = psel && penable && pwrite;
    wire logic hit_ctrl = (paddr == OFF_CTRL);
    wire logic hit_file = (paddr == OFF_FILE);
    wire logic hit_acc = (paddr == OFF_ACC);
    wire logic hit_status = (paddr == OFF_STATUS);
    wire logic hit_dir = (paddr == OFF_DIR);
    wire logic hit_result = (paddr == OFF_RESULT);
    wire logic mapped = hit_ctrl | hit_file | hit_acc | hit_status
        | hit_dir | hit_result;
    // Single-cycle access phase; unmapped gives an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    // Operands come straight off the write data so an op runs at its
    // own access edge; ctrl keeps the pointer for FILE accesses and the word for read-back
    wire logic go = wr_en && hit_ctrl && pwdata[CTRL_GO];
    wire logic [2:0] op = pwdata[CTRL_OP_MSB:CTRL_OP_LSB];
    wire logic dest = pwdata[CTRL_DEST];
    wire logic [ADDR_W-1:0] faddr = pwdata[CTRL_ADDR_MSB:CTRL_ADDR_LSB];
    wire logic [DATA_W-1:0] imm = pwdata[CTRL_IMM_MSB:CTRL_IMM_LSB];
    wire logic [SEL_W-1:0] sel = faddr[SEL_W-1:0];
    wire logic [DATA_W-1:0] fval = file_mem[faddr];
    // File data is written back via the FILE word at the CTRL address field
    wire logic [ADDR_W-1:0] ptr = ctrl[CTRL_ADDR_MSB:CTRL_ADDR_LSB];

    // ------------------------------------------------------------
    // Arithmetic: borrow-in is the inverted carry for the borrow form
    // ------------------------------------------------------------
    wire logic bin = (op == OP_SUBB) ? ~carry : 1'b0;
    // One extra bit holds the raw borrow; it is inverted into the
    // borrow-not sense that the carry and nibble flags keep
    wire logic [DATA_W:0] diff = {1'b0, fval} - {1'b0, acc}
        - {{DATA_W{1'b0}}, bin};
    wire logic [NIB_W:0] ndiff = {1'b0, fval[NIB_W-1:0]}
        - {1'b0, acc[NIB_W-1:0]} - {{NIB_W{1'b0}}, bin};
    wire logic sub_c = ~diff[DATA_W];
    wire logic sub_dc = ~ndiff[NIB_W];
    wire logic [DATA_W-1:0] swapped = {fval[NIB_W-1:0],
        fval[DATA_W-1:NIB_W]};
    wire logic is_sub = (op == OP_SUB) || (op == OP_SUBB);
    wire logic is_xor = (op == OP_XORI) || (op == OP_XORF);
    wire logic to_file = dest && (op != OP_XORI) && (op != OP_DIR);

    // Result select; unknown codes fall back to the accumulator
    wire logic [DATA_W-1:0] next_result =
        is_sub ? diff[DATA_W-1:0]
        : (op == OP_SWAP) ? swapped
        : (op == OP_XORI) ? (acc ^ imm)
        : (op == OP_XORF) ? (acc ^ fval)
        : acc;
    wire logic next_zero = (next_result == BYTE_ZERO);
    wire logic known = is_sub || is_xor || (op == OP_SWAP) || (op == OP_DIR);
    // Write enables; an unknown code with GO only lands in the control word
    wire logic run = go && known;
    wire logic acc_from_op = run && !to_file && (op != OP_DIR);
    wire logic file_from_op = run && to_file;

    // ------------------------------------------------------------
    // Control word and result register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h0000_0000;
            result <= BYTE_ZERO;
        end else if (wr_en && hit_ctrl) begin
            ctrl <= pwdata;
            if (run) begin
                result <= next_result;
            end
        end
    end

    // Accumulator: bus write or instruction destination 0 (XORI with either destination, DIR never)
    // The instruction wins; they come from different words on one bus so they never meet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= BYTE_ZERO;
        end else if (acc_from_op) begin
            acc <= next_result;
        end else if (wr_en && hit_acc) begin
            acc <= pwdata[DATA_W-1:0];
        end
    end

    // File store; no reset, it models register file contents
    always_ff @(posedge pclk) begin
        if (file_from_op) begin
            file_mem[faddr] <= next_result;
        end else if (wr_en && hit_file) begin
            file_mem[ptr] <= pwdata[DATA_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Status flags: swap and direction load leave all untouched
    // ------------------------------------------------------------
    // Instruction flags beat a STATUS write; they come from different
    // words on one bus, so the two can never fall in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry <= 1'b0;
            nib <= 1'b0;
            zero <= 1'b0;
        end else if (go && is_sub) begin
            carry <= sub_c;
            nib <= sub_dc;
            zero <= next_zero;
        end else if (go && is_xor) begin
            zero <= next_zero;
        end else if (wr_en && hit_status) begin
            carry <= pwdata[ST_CARRY];
            nib <= pwdata[ST_NIB];
            zero <= pwdata[ST_ZERO];
        end
    end

    // ------------------------------------------------------------
    // Direction latches; other selector values are ignored
    // ------------------------------------------------------------
    // Direction decode; operands with upper bits set are out of range
    wire logic dir_go = go && (op == OP_DIR);
    wire logic dir_in_range = (faddr[ADDR_W-1:SEL_W] == '0);
    wire logic load_a = dir_go && dir_in_range && (sel == SEL_PORT_A);
    wire logic load_b = dir_go && dir_in_range && (sel == SEL_PORT_B);
    wire logic load_c = dir_go && dir_in_range && (sel == SEL_PORT_C);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_latch_port_a <= DIR_RESET;
            dir_latch_port_b <= DIR_RESET;
            dir_latch_port_c <= DIR_RESET;
        end else begin
            if (load_a) begin
                dir_latch_port_a <= acc;
            end
            if (load_b) begin
                dir_latch_port_b <= acc;
            end
            if (load_c) begin
                dir_latch_port_c <= acc;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path: word picked by address, then held in a flop
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] file_rd = file_mem[ptr];
    wire logic [31:0] rd_status = (32'(zero) << ST_ZERO)
        | (32'(nib) << ST_NIB) | (32'(carry) << ST_CARRY);
    // GO reads back as zero so a read-modify-write cannot re-run an op
    wire logic [31:0] next_prdata =
        hit_ctrl ? {1'b0, ctrl[CTRL_GO-1:0]}
        : hit_file ? 32'(file_rd)
        : hit_acc ? 32'(acc)
        : hit_status ? rd_status
        : hit_dir ? {BYTE_ZERO, dir_latch_port_c, dir_latch_port_b,
            dir_latch_port_a}
        : hit_result ? 32'(result)
        : 32'h0000_0000;
    wire logic rd_setup = psel && !penable;

    // Captured at every setup edge, so the word stands through the access
    // phase; registers only change at access edges, so it is never stale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end
endmodule

// file: alu_pkg.sv
// Package: constants for the byte ALU slice
package alu_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int SEL_W = 3;
    localparam int NIB_W = 4;
    // Register offsets of the APB-visible words
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FILE = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_DIR = 8'h10;
    localparam logic [7:0] OFF_RESULT = 8'h14;
    // CTRL field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_MSB = 2;
    localparam int CTRL_DEST = 3;
    localparam int CTRL_ADDR_LSB = 8;
    localparam int CTRL_ADDR_MSB = 14;
    localparam int CTRL_IMM_LSB = 16;
    localparam int CTRL_IMM_MSB = 23;
    localparam int CTRL_GO = 31;
    // STATUS field positions
    localparam int ST_CARRY = 0;
    localparam int ST_NIB = 1;
    localparam int ST_ZERO = 2;
    // Direction-load selector values
    localparam logic [SEL_W-1:0] SEL_PORT_A = 3'h5;
    localparam logic [SEL_W-1:0] SEL_PORT_B = 3'h6;
    localparam logic [SEL_W-1:0] SEL_PORT_C = 3'h7;
    // Reset values
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    // Operation codes
    localparam logic [2:0] OP_SUB = 3'h0;
    localparam logic [2:0] OP_SUBB = 3'h1;
    localparam logic [2:0] OP_SWAP = 3'h2;
    localparam logic [2:0] OP_XORI = 3'h3;
    localparam logic [2:0] OP_XORF = 3'h4;
    localparam logic [2:0] OP_DIR = 3'h5;
endpackage

// file: byte_alu_assertions.sv
// Checker: port-level properties of the byte ALU slice
`timescale 1ns/10ps
module byte_alu_checker
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Direction latches
    input wire logic [DATA_W-1:0] dir_latch_port_a,
    input wire logic [DATA_W-1:0] dir_latch_port_b,
    input wire logic [DATA_W-1:0] dir_latch_port_c
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A latch may only move after a load command aimed at it
    wire acc_e = psel && penable;
    wire go_dir = acc_e && pwrite && paddr == OFF_CTRL && pwdata[CTRL_GO]
        && pwdata[2:0] == OP_DIR;
    property p_ready; acc_e |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_unmap; acc_e && paddr > OFF_RESULT |-> pslverr && prdata == 0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_mapped; acc_e && paddr == OFF_ACC |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_dir_a; $changed(dir_latch_port_a) |->
        $past(go_dir && pwdata[14:8] == 7'h05); endproperty
    a_dir_a: assert property (p_dir_a) else $error("latch a moved");
    property p_dir_b; $changed(dir_latch_port_b) |->
        $past(go_dir && pwdata[14:8] == 7'h06); endproperty
    a_dir_b: assert property (p_dir_b) else $error("latch b moved");
    property p_dir_c; $changed(dir_latch_port_c) |->
        $past(go_dir && pwdata[14:8] == 7'h07); endproperty
    a_dir_c: assert property (p_dir_c) else $error("latch c moved");
    property p_dir_rd; acc_e && !pwrite && paddr == OFF_DIR |-> prdata ==
        {8'h00, dir_latch_port_c, dir_latch_port_b, dir_latch_port_a};
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("dir read");
    property p_go_rd; acc_e && !pwrite && paddr == OFF_CTRL |-> !prdata[31];
    endproperty
    a_go_rd: assert property (p_go_rd) else $error("go bit read back");
endmodule
bind byte_alu byte_alu_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dir_latch_port_a(dir_latch_port_a), .dir_latch_port_b(dir_latch_port_b),
    .dir_latch_port_c(dir_latch_port_c));

// file: apb_master.sv
// APB master model standing in for the core's decoder side
`timescale 1ns/10ps
module apb_master (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Request held until ready is seen at an edge, waits have no bound
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: tb_top.sv
// Testbench: instruction rows over APB, then reset and refusal cases
`timescale 1ns/10ps
module tb_top
    import alu_pkg::*;
;
    typedef struct {logic [2:0] op; logic d; logic [6:0] a; logic [7:0] k;
        logic [7:0] w; logic [7:0] f; logic [2:0] s; logic [7:0] r;
        logic [2:0] st;} row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, dir_a, dir_b, dir_c;
    logic [31:0] pwdata, prdata, rd, exp_dir;
    int err_count = 0;
    int checks = 0;
    // Inputs: op, dest, addr, imm, acc, file, status; then result, status
    row_s rows [10] = '{
        '{OP_SUB, 1'b0, 7'h10, 8'h0, 8'h05, 8'h03, 3'h1, 8'hFE, 3'h0},
        '{OP_SUB, 1'b1, 7'h7F, 8'h0, 8'h22, 8'h22, 3'h0, 8'h00, 3'h7},
        '{OP_SUBB, 1'b0, 7'h01, 8'h0, 8'h01, 8'h10, 3'h0, 8'h0E, 3'h1},
        '{OP_SUBB, 1'b1, 7'h02, 8'h0, 8'h0F, 8'h10, 3'h1, 8'h01, 3'h1},
        '{OP_SWAP, 1'b1, 7'h03, 8'h0, 8'h11, 8'hA5, 3'h6, 8'h5A, 3'h6},
        '{OP_XORI, 1'b0, 7'h04, 8'hFF, 8'h0F, 8'h0, 3'h3, 8'hF0, 3'h3},
        '{OP_XORI, 1'b1, 7'h04, 8'h3C, 8'h3C, 8'h0, 3'h0, 8'h00, 3'h4},
        '{OP_XORF, 1'b1, 7'h05, 8'h0, 8'hAA, 8'hAA, 3'h3, 8'h00, 3'h7},
        '{OP_XORF, 1'b0, 7'h06, 8'h0, 8'h12, 8'h34, 3'h7, 8'h26, 3'h3},
        '{OP_SWAP, 1'b0, 7'h07, 8'h0, 8'h00, 8'h3C, 3'h1, 8'hC3, 3'h1}};
    byte_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dir_latch_port_a(dir_a), .dir_latch_port_b(dir_b),
        .dir_latch_port_c(dir_c));
    apb_master mst_u (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    function automatic logic [31:0] ctrl(logic go, logic [2:0] op, logic d,
        logic [6:0] a, logic [7:0] k);
        return {go, 7'h0, k, 1'b0, a, 4'h0, d, op};
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mst_u.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, logic [31:0] e);
        mst_u.xfer(1'b0, a, 32'h0, rd, err);
        chk(n, rd, e);
    endtask
    task automatic give_verdict;
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Clock and reset
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        err_count++;
        give_verdict;
    end
    initial begin
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc("dir_rst", OFF_DIR, 32'h00FFFFFF);
        rdc("acc_rst", OFF_ACC, 32'h0);
        foreach (rows[i]) begin
            wr(OFF_CTRL, ctrl(1'b0, rows[i].op, rows[i].d, rows[i].a, 8'h0));
            wr(OFF_FILE, {24'h0, rows[i].f});
            wr(OFF_ACC, {24'h0, rows[i].w});
            wr(OFF_STATUS, {29'h0, rows[i].s});
            wr(OFF_CTRL, ctrl(1'b1, rows[i].op, rows[i].d, rows[i].a,
                rows[i].k));
            rdc("result", OFF_RESULT, {24'h0, rows[i].r});
            rdc("status", OFF_STATUS, {29'h0, rows[i].st});
            if (rows[i].d && rows[i].op != OP_XORI) begin
                rdc("file", OFF_FILE, {24'h0, rows[i].r});
                rdc("acc_kept", OFF_ACC, {24'h0, rows[i].w});
            end else
                rdc("acc", OFF_ACC, {24'h0, rows[i].r});
        end
        // Selector 4 is in range but matches no port and must load nothing
        exp_dir = 32'h00FFFFFF;
        wr(OFF_STATUS, 32'h5);
        for (int s = 4; s < 8; s++) begin
            wr(OFF_ACC, s);
            wr(OFF_CTRL, ctrl(1'b1, OP_DIR, 1'b0, 7'(s), 8'h0));
            if (s > 4)
                exp_dir[8*(s-5) +: 8] = 8'(s);
            rdc("dir", OFF_DIR, exp_dir);
            rdc("dir_status", OFF_STATUS, 32'h5);
        end
        chk("dir_a_pin", {24'h0, dir_a}, 32'h05);
        chk("dir_b_pin", {24'h0, dir_b}, 32'h06);
        chk("dir_c_pin", {24'h0, dir_c}, 32'h07);
        // Low bits pick port A but the upper operand bits are set
        wr(OFF_ACC, 32'h09);
        wr(OFF_CTRL, ctrl(1'b1, OP_DIR, 1'b0, 7'h0D, 8'h0));
        rdc("dir_range", OFF_DIR, exp_dir);
        rdc("ctrl_rd", OFF_CTRL, ctrl(1'b0, OP_DIR, 1'b0, 7'h0D, 8'h0));
        // Unknown code with GO: control word only, nothing else moves
        wr(OFF_CTRL, ctrl(1'b1, 3'h6, 1'b1, 7'h7F, 8'h0));
        rdc("unk_acc", OFF_ACC, 32'h09);
        rdc("unk_file", OFF_FILE, 32'h00);
        rdc("unk_status", OFF_STATUS, 32'h5);
        wr(8'h20, 32'hFF);
        rdc("unmapped", 8'h20, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        // Reset again in mid-run: latches, accumulator and status return to reset
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("dir_a_rst", {24'h0, dir_a}, 32'hFF);
        rdc("dir_rst2", OFF_DIR, 32'h00FFFFFF);
        rdc("acc_rst2", OFF_ACC, 32'h0);
        rdc("status_rst2", OFF_STATUS, 32'h0);
        give_verdict;
    end
endmodule
